/* inc/tcc_pkg.sv */
// timer 2 capture/control package: register addresses, control bit positions, prescaler counts.
// assumes a byte-wide special-function register port in the surrounding core.
package tcc_pkg;

  // ***********************************************
  // register addresses
  // ***********************************************
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;

  // ***********************************************
  // control register layout and reset
  // ***********************************************
  localparam int BIT_HIGH_OVF = 7;
  localparam int BIT_LOW_OVF = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_SOURCE = 1;
  localparam int BIT_EXT_CLK = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ***********************************************
  // clock prescaling and capture source
  // ***********************************************
  localparam int SYS_DIVIDE = 12;
  localparam int EXT_DIVIDE = 8;
  localparam logic SOURCE_SOF = 1'b0;

  // register port request carried as one bundle
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcc_req_t;

endpackage : tcc_pkg

/* hdl/tcc_timer2.sv */
// timer 2 with capture mode: counter bytes, reload bytes and control register.
// assumes all inputs are synchronous to clock; capture events arrive as one-cycle pulses or levels.
`timescale 1ns/100ps

module tcc_timer2 (
  input wire logic clock, // system clock, 10 MHz
  input wire logic reset, // synchronous, active high
  input wire tcc_pkg::tcc_req_t req, // register write request and address
  output logic [7:0] reg_rdata, // registered read data for req.addr
  input wire logic sof_event, // start-of-frame pulse
  input wire logic low_freq_oscillator, // oscillator level
  input wire logic external_clock, // external oscillator level
  input wire logic high_byte_system_clock_select, // high byte on system clock, split mode only
  input wire logic low_byte_system_clock_select, // low byte on system clock
  input wire logic timer_irq_enable, // timer interrupts enabled
  output logic timer_irq // one-cycle interrupt request
);

  logic [7:0] timer2_control;
  logic [7:0] count_high_byte;
  logic [7:0] count_low_byte;
  logic [7:0] reload_high_byte;
  logic [7:0] reload_low_byte;
  logic [3:0] sys_div;
  logic [2:0] ext_div;
  logic ext_last;
  logic lfo_last;
  logic sys_tick;
  logic ext_tick;
  logic slow_tick;
  logic tick_high;
  logic tick_low;
  logic inc_high;
  logic inc_low;
  logic wrap_high;
  logic wrap_low;
  logic capture;
  logic capture_en;
  logic split_mode_bit;
  logic run_control_bit;

  function automatic logic wr_to(input tcc_pkg::tcc_req_t r, input logic [7:0] a);
    wr_to = r.wr && (r.addr == a);
  endfunction : wr_to

  // ***********************************************
  // prescalers
  // ***********************************************
  assign sys_tick = (sys_div == 4'(tcc_pkg::SYS_DIVIDE - 1));
  assign ext_tick = external_clock && !ext_last && (ext_div == 3'(tcc_pkg::EXT_DIVIDE - 1));
  assign slow_tick = timer2_control[tcc_pkg::BIT_EXT_CLK] ? ext_tick : sys_tick;
  assign tick_high = high_byte_system_clock_select ? 1'b1 : slow_tick;
  assign tick_low = low_byte_system_clock_select ? 1'b1 : slow_tick;

  always_ff @(posedge clock) begin
    if (reset) begin
      sys_div <= 4'h0;
    end else if (sys_tick) begin
      sys_div <= 4'h0;
    end else begin
      sys_div <= sys_div + 4'h1;
    end
  end

  // external clock edges are counted here, so its rate must stay below half the system clock
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_div <= 3'h0;
      ext_last <= 1'b0;
    end else begin
      ext_last <= external_clock;
      if (external_clock && !ext_last) begin
        ext_div <= ext_div + 3'h1;
      end
    end
  end

  // ***********************************************
  // mode and capture event
  // ***********************************************
  assign capture_en = timer2_control[tcc_pkg::BIT_CAPTURE_EN];
  assign split_mode_bit = timer2_control[tcc_pkg::BIT_SPLIT];
  assign run_control_bit = timer2_control[tcc_pkg::BIT_RUN];

  always_ff @(posedge clock) begin
    if (reset) begin
      lfo_last <= 1'b0;
    end else begin
      lfo_last <= low_freq_oscillator;
    end
  end

  assign capture = capture_en && ((timer2_control[tcc_pkg::BIT_SOURCE] == tcc_pkg::SOURCE_SOF)
                   ? sof_event : (lfo_last && !low_freq_oscillator));

  // ***********************************************
  // counters
  // ***********************************************
  // in 16-bit mode the low byte's clock drives the pair and the high byte rides its carry
  assign inc_low = split_mode_bit ? tick_low : (tick_low && run_control_bit);
  assign inc_high = split_mode_bit ? (tick_high && run_control_bit)
                    : (inc_low && count_low_byte == 8'hFF);
  assign wrap_low = inc_low && (count_low_byte == 8'hFF);
  assign wrap_high = inc_high && (count_high_byte == 8'hFF);

  always_ff @(posedge clock) begin
    if (reset) begin
      count_low_byte <= tcc_pkg::BYTE_RESET;
    end else if (wr_to(req, tcc_pkg::ADDR_COUNT_LOW)) begin
      count_low_byte <= req.wdata;
    end else if (wrap_low && !capture_en && split_mode_bit) begin
      count_low_byte <= reload_low_byte;
    end else if (wrap_low && !capture_en && wrap_high) begin
      count_low_byte <= reload_low_byte;
    end else if (inc_low) begin
      count_low_byte <= count_low_byte + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_high_byte <= tcc_pkg::BYTE_RESET;
    end else if (wr_to(req, tcc_pkg::ADDR_COUNT_HIGH)) begin
      count_high_byte <= req.wdata;
    end else if (wrap_high && !capture_en) begin
      count_high_byte <= reload_high_byte;
    end else if (inc_high) begin
      count_high_byte <= count_high_byte + 8'h01;
    end
  end

  // ***********************************************
  // reload / capture registers
  // ***********************************************
  // a capture overrides a software write in the same cycle: the measurement must not be lost
  always_ff @(posedge clock) begin
    if (reset) begin
      reload_low_byte <= tcc_pkg::BYTE_RESET;
      reload_high_byte <= tcc_pkg::BYTE_RESET;
    end else if (capture) begin
      reload_low_byte <= count_low_byte;
      reload_high_byte <= count_high_byte;
    end else begin
      if (wr_to(req, tcc_pkg::ADDR_RELOAD_LOW)) begin
        reload_low_byte <= req.wdata;
      end
      if (wr_to(req, tcc_pkg::ADDR_RELOAD_HIGH)) begin
        reload_high_byte <= req.wdata;
      end
    end
  end

  // ***********************************************
  // control register, overflow flags
  // ***********************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      timer2_control <= tcc_pkg::CONTROL_RESET;
    end else begin
      if (wr_to(req, tcc_pkg::ADDR_CONTROL)) begin
        timer2_control <= req.wdata;
      end
      // hardware set wins over a software clear in the same cycle
      if (wrap_high) begin
        timer2_control[tcc_pkg::BIT_HIGH_OVF] <= 1'b1;
      end
      if (wrap_low) begin
        timer2_control[tcc_pkg::BIT_LOW_OVF] <= 1'b1;
      end
    end
  end

  // ***********************************************
  // interrupt request and read data
  // ***********************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= timer_irq_enable && (capture
                   || (wrap_high && !capture_en)
                   || (wrap_low && timer2_control[tcc_pkg::BIT_LOW_IRQ_EN]));
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (req.addr == tcc_pkg::ADDR_CONTROL) begin
      reg_rdata <= timer2_control;
    end else if (req.addr == tcc_pkg::ADDR_RELOAD_LOW) begin
      reg_rdata <= reload_low_byte;
    end else if (req.addr == tcc_pkg::ADDR_RELOAD_HIGH) begin
      reg_rdata <= reload_high_byte;
    end else if (req.addr == tcc_pkg::ADDR_COUNT_LOW) begin
      reg_rdata <= count_low_byte;
    end else if (req.addr == tcc_pkg::ADDR_COUNT_HIGH) begin
      reg_rdata <= count_high_byte;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : tcc_timer2

/* verif/tcc_event_src.sv */
// event source model: frame pulses, oscillator falling edges and a free-running external clock.
// assumes fire is driven just after a rising edge and held for one cycle.
`timescale 1ns/100ps
module tcc_event_src (
  input wire logic clock, // system clock
  input wire logic reset, // bench reset, restarts the external clock phase
  input wire logic fire, // one event request
  input wire logic use_lfo, // 1 selects the oscillator edge
  output logic sof_event, // frame pulse
  output logic low_freq_oscillator, // idles high
  output logic external_clock // slow free-running clock
);
  logic [1:0] div;
  // restarting with reset fixes where the slow ticks land in each scenario
  always_ff @(posedge clock) begin
    if (reset) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end
  assign sof_event = fire && !use_lfo;
  // idling high makes every fire with use_lfo set a clean falling edge
  assign low_freq_oscillator = !(fire && use_lfo);
  assign external_clock = div[1];
endmodule : tcc_event_src

/* verif/tcc_timer2_monitor.sv */
// checker for the timer 2 capture block, watching only the top ports.
// assumes the control register's software bits change only by writes through req.
`timescale 1ns/100ps
module tcc_timer2_monitor (
  input wire logic clock, // clock
  input wire logic reset, // sync reset
  input wire tcc_pkg::tcc_req_t req, // register request
  input wire logic [7:0] reg_rdata, // read data
  input wire logic sof_event, // frame pulse
  input wire logic low_freq_oscillator, // oscillator
  input wire logic external_clock, // ext clock
  input wire logic high_byte_system_clock_select, // high select
  input wire logic low_byte_system_clock_select, // low select
  input wire logic timer_irq_enable, // irq enable
  input wire logic timer_irq // irq pulse
);
  // software bits only; the flags are hardware-set and not tracked
  logic [5:0] ctl;
  always_ff @(posedge clock) begin
    if (reset)
      ctl <= 6'h00;
    else if (req.wr && req.addr == tcc_pkg::ADDR_CONTROL)
      ctl <= req.wdata[5:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_reset_clears: assert property (disable iff (1'b0) reset |=> reg_rdata == 8'h00 && !timer_irq)
    else $error("reset left state");
  a_unmapped_zero: assert property (!(req.addr inside {8'hC8, [8'hCA:8'hCD]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_control_readback: assert property (req.addr == 8'hC8 |=> reg_rdata[5:0] == $past(ctl))
    else $error("control readback wrong");
  a_capture_irq: assert property (timer_irq_enable && ctl[4] && (ctl[1] ? $fell(low_freq_oscillator) : sof_event) |=> timer_irq)
    else $error("capture without irq");
  a_irq_gated: assert property (!timer_irq_enable |=> !timer_irq)
    else $error("irq while disabled");
  a_no_spurious_irq: assert property (ctl[4] && !ctl[5] && !(ctl[1] ? $fell(low_freq_oscillator) : sof_event) |=> !timer_irq)
    else $error("irq without capture");
  a_low_counts: assert property ((ctl[4] && (ctl[3] || ctl[2]) && low_byte_system_clock_select && req.addr == 8'hCC && !req.wr) [*2] |=> reg_rdata == $past(reg_rdata) + 8'h01)
    else $error("low byte step wrong");
  a_high_frozen: assert property ((ctl[4:2] == 3'b110 && req.addr == 8'hCD && !req.wr) [*2] |=> $stable(reg_rdata))
    else $error("high byte ran while stopped");
  c_sof: cover property (ctl[4] && !ctl[1] && sof_event ##1 timer_irq);
  c_lfo: cover property (ctl[4] && ctl[1] && $fell(low_freq_oscillator) ##1 timer_irq);
  c_split: cover property (ctl[4:3] == 2'b11 && req.addr == 8'hCD);
endmodule : tcc_timer2_monitor
bind tcc_timer2 tcc_timer2_monitor u_mon (
  .clock(clock),
  .reset(reset),
  .req(req),
  .reg_rdata(reg_rdata),
  .sof_event(sof_event),
  .low_freq_oscillator(low_freq_oscillator),
  .external_clock(external_clock),
  .high_byte_system_clock_select(high_byte_system_clock_select),
  .low_byte_system_clock_select(low_byte_system_clock_select),
  .timer_irq_enable(timer_irq_enable),
  .timer_irq(timer_irq)
);

/* verif/testbench.sv */
// self-checking bench for the timer 2 capture block, driven through its register port.
// assumes the event source model and the bound checker.
`timescale 1ns/100ps
module testbench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  tcc_pkg::tcc_req_t req = '0;
  logic [7:0] reg_rdata;
  logic sof_event, low_freq_oscillator, external_clock, timer_irq;
  logic hsel = 1'b1;
  logic lsel = 1'b1;
  logic en = 1'b0;
  logic fire = 1'b0;
  logic kind = 1'b0;
  int fail_count = 0;
  int samples_checked = 0;
  always #50 clock = ~clock;
  tcc_event_src src (.clock(clock), .reset(reset), .fire(fire), .use_lfo(kind),
    .sof_event(sof_event),
    .low_freq_oscillator(low_freq_oscillator), .external_clock(external_clock));
  tcc_timer2 dut (.clock(clock), .reset(reset), .req(req), .reg_rdata(reg_rdata),
    .sof_event(sof_event), .low_freq_oscillator(low_freq_oscillator),
    .external_clock(external_clock), .high_byte_system_clock_select(hsel),
    .low_byte_system_clock_select(lsel), .timer_irq_enable(en), .timer_irq(timer_irq));
  task automatic end_sim;
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = {1'b1, a, d};
    @(posedge clock);
    #1;
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    req.addr = a;
    @(posedge clock);
    #1;
    check(n, e, reg_rdata);
  endtask : rd
  // the count starts at the edge after the control write, so with the low byte on the system clock n waits capture the value n
  task automatic scen(input logic [7:0] c, input logic s, e, k, input int n,
    input logic [7:0] hi, lo, cx, input logic ir);
    reset = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    reset = 1'b0;
    hsel = s;
    en = e;
    kind = k;
    wr(tcc_pkg::ADDR_CONTROL, c);
    req.addr = c[2] ? tcc_pkg::ADDR_COUNT_LOW : tcc_pkg::ADDR_COUNT_HIGH;
    repeat (n) @(posedge clock);
    #1;
    fire = 1'b1;
    @(posedge clock);
    #1;
    fire = 1'b0;
    check("irq", {7'h00, ir}, {7'h00, timer_irq});
    rd(tcc_pkg::ADDR_RELOAD_HIGH, hi, "reload_high");
    rd(tcc_pkg::ADDR_RELOAD_LOW, lo, "reload_low");
    rd(tcc_pkg::ADDR_CONTROL, cx, "control");
  endtask : scen
  initial begin
    scen(8'h14, 1'b1, 1'b1, 1'b0, 299, 8'h01, 8'h2B, 8'h54, 1'b1);
    scen(8'h1A, 1'b0, 1'b1, 1'b1, 9, 8'h00, 8'h09, 8'h1A, 1'b1);
    scen(8'h1E, 1'b1, 1'b0, 1'b1, 299, 8'h2B, 8'h2B, 8'hDE, 1'b0);
    scen(8'h04, 1'b1, 1'b1, 1'b0, 9, 8'h00, 8'h00, 8'h04, 1'b0);
    scen(8'h16, 1'b1, 1'b1, 1'b0, 9, 8'h00, 8'h00, 8'h16, 1'b0);
    lsel = 1'b0;
    // slow ticks: /12 on edges 12, 24 .. 300; external /8 on edges 31, 63 .. 287
    scen(8'h14, 1'b1, 1'b1, 1'b0, 299, 8'h00, 8'h19, 8'h14, 1'b1);
    scen(8'h1D, 1'b0, 1'b1, 1'b0, 299, 8'h09, 8'h09, 8'h1D, 1'b1);
    rd(8'hC9, 8'h00, "unmapped");
    end_sim();
  end
endmodule : testbench
